/* bwio_port.sv */
// bytewise general-purpose i/o port with its registers
`timescale 1ns/10ps
module bwio_port
  import bwio_pkg::*;
#(
  parameter int W = BWIO_WIDTH
) (
  input  wire logic         ref_clk,    // system clock, 200 mhz
  input  wire logic         rst,        // asynchronous reset, active high
  input  wire logic [1:0]   addr,       // register select
  input  wire logic         wr_en,      // write strobe
  input  wire logic         rd_en,      // read strobe
  input  wire logic [W-1:0] wdata,      // write data
  output logic      [W-1:0] rdata,      // read data, registered
  input  wire logic [W-1:0] pin_in,     // pin levels
  output logic      [W-1:0] pin_out,    // pin output values
  output logic      [W-1:0] pin_oe_n,   // pin enables, low drives
  output logic      [W-1:0] pull_en,    // pull-up enables
  output logic      [W-1:0] ana_sel,    // converter mux selects
  output logic              port_irq    // port interrupt request, one-cycle pulse in edge modes, level in low mode
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [W-1:0] data_r, data_nxt, dir_r, dir_nxt, opt_r, opt_nxt;
  logic [W-1:0] rdata_r, rdata_nxt;
  logic [1:0]   trig_r, trig_nxt;
  logic [W-1:0] sync1_r, sync2_r, prev_r;
  logic [W-1:0] irq_sel, read_bits;
  logic         irq_r, irq_nxt;

  // writes land on the edge that takes them; a read sees them one edge later
  always_comb begin
    data_nxt = data_r;
    dir_nxt  = dir_r;
    opt_nxt  = opt_r;
    trig_nxt = trig_r;
    if (wr_en) begin
      case (addr)
        BWIO_ADDR_DATA: data_nxt = wdata;
        BWIO_ADDR_DIR:  dir_nxt  = wdata;
        BWIO_ADDR_OPT:  opt_nxt  = wdata;
        BWIO_ADDR_TRIG: trig_nxt = wdata[1:0];
        default:        data_nxt = data_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_r <= W'(BWIO_RESET_VAL);
      dir_r  <= W'(BWIO_RESET_VAL);
      opt_r  <= W'(BWIO_RESET_VAL);
      trig_r <= BWIO_TRIG_RESET;
    end else begin
      data_r <= data_nxt;
      dir_r  <= dir_nxt;
      opt_r  <= opt_nxt;
      trig_r <= trig_nxt;
    end
  end

  // ****************************************************************
  // read data: held until the next read strobe
  // ****************************************************************
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      case (addr)
        BWIO_ADDR_DATA: rdata_nxt = read_bits;
        BWIO_ADDR_DIR:  rdata_nxt = dir_r;
        BWIO_ADDR_OPT:  rdata_nxt = opt_r;
        BWIO_ADDR_TRIG: rdata_nxt = {{(W-2){1'b0}}, trig_r};
        default:        rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // pin synchroniser and edge history
  // ****************************************************************
  // pins are asynchronous: two flops before any logic reads them; the
  // history resets high, the idle level of a pulled-up line, so that
  // no false edge follows reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r  <= '1;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ****************************************************************
  // per-line configuration
  // ****************************************************************
  for (genvar i = 0; i < W; i++) begin : g_line
    bwio_line u_line (
      .dir      (dir_r[i]),
      .opt      (opt_r[i]),
      .dat      (data_r[i]),
      .pin_sync (sync2_r[i]),
      .pin_out  (pin_out[i]),
      .pin_oe_n (pin_oe_n[i]),
      .pull_en  (pull_en[i]),
      .irq_sel  (irq_sel[i]),
      .ana_sel  (ana_sel[i]),
      .read_bit (read_bits[i])
    );
  end

  // ****************************************************************
  // trigger: edge modes give a one-cycle request, low level holds
  // ****************************************************************
  always_comb begin
    case (trig_r)
      BWIO_TRIG_FALL: irq_nxt = |(irq_sel & prev_r & ~sync2_r);
      BWIO_TRIG_RISE: irq_nxt = |(irq_sel & ~prev_r & sync2_r);
      BWIO_TRIG_LOW:  irq_nxt = |(irq_sel & ~sync2_r);
      default:        irq_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign rdata    = rdata_r;
  assign port_irq = irq_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_reset_clear: assert property (@(posedge ref_clk) $fell(rst) |-> pull_en == '1)
    else $error("lines not pulled up after reset");

  chk_reset_regs: assert property (@(posedge ref_clk)
    $fell(rst) |-> (data_r == '0 && dir_r == '0 && opt_r == '0 && trig_r == BWIO_TRIG_RESET))
    else $error("registers not cleared by reset");

  chk_output_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (dir_r[0] && opt_r[0]) |-> (!pin_oe_n[0] && pin_out[0] == data_r[0]))
    else $error("push-pull line not driving latch value");

  chk_open_drain: assert property (@(posedge ref_clk) disable iff (rst)
    (dir_r[0] && !opt_r[0] && data_r[0]) |-> pin_oe_n[0])
    else $error("open-drain line drives high");

  chk_input_drive: assert property (@(posedge ref_clk) disable iff (rst)
    (pin_oe_n | dir_r) == '1)
    else $error("input line driven");

  chk_hiz_input: assert property (@(posedge ref_clk) disable iff (rst)
    (!dir_r[0] && !opt_r[0] && data_r[0]) |-> (pin_oe_n[0] && !pull_en[0]))
    else $error("no-pull input not high impedance");

  chk_pull_map: assert property (@(posedge ref_clk) disable iff (rst)
    pull_en == (~dir_r & ~data_r))
    else $error("pull-up on wrong lines");

  chk_irq_map: assert property (@(posedge ref_clk) disable iff (rst)
    irq_sel == (~dir_r & opt_r & ~data_r))
    else $error("interrupt select on wrong lines");

  chk_analog_sel: assert property (@(posedge ref_clk) disable iff (rst)
    ana_sel[0] |-> (!dir_r[0] && opt_r[0] && data_r[0] && pin_oe_n[0]))
    else $error("analog select in wrong mode");

  chk_analog_map: assert property (@(posedge ref_clk) disable iff (rst)
    ana_sel == (~dir_r & opt_r & data_r))
    else $error("analog select on wrong lines");

  chk_write_latch: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && addr == BWIO_ADDR_DIR) |=> dir_r == $past(wdata))
    else $error("direction write lost");

  chk_data_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && addr == BWIO_ADDR_DATA) |=> data_r == $past(wdata))
    else $error("data write lost");

  chk_read_pins: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_en && addr == BWIO_ADDR_DATA && dir_r == '0 && opt_r == '0)
      |=> rdata == $past(sync2_r))
    else $error("input read not from pins");

  chk_read_latch: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_en && addr == BWIO_ADDR_DATA && dir_r == '1) |=> rdata == $past(data_r))
    else $error("output read not from latch");

  chk_rdata_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !rd_en |=> $stable(rdata))
    else $error("read data changed without a read");

  chk_fall_irq: assert property (@(posedge ref_clk) disable iff (rst)
    (trig_r == BWIO_TRIG_FALL && |(irq_sel & prev_r & ~sync2_r)) |=> port_irq)
    else $error("falling edge interrupt missing");

  chk_rise_irq: assert property (@(posedge ref_clk) disable iff (rst)
    (trig_r == BWIO_TRIG_RISE && |(irq_sel & ~prev_r & sync2_r)) |=> port_irq)
    else $error("rising edge interrupt missing");

  chk_low_irq: assert property (@(posedge ref_clk) disable iff (rst)
    (trig_r == BWIO_TRIG_LOW && |(irq_sel & ~sync2_r)) |=> port_irq)
    else $error("low level interrupt missing");

  chk_irq_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_sel == '0) |=> !port_irq)
    else $error("interrupt with no line selected");
endmodule

/* bwio_pkg.sv */
// package of constants for the bytewise i/o port
package bwio_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [1:0] BWIO_ADDR_DATA = 2'h0;
  localparam logic [1:0] BWIO_ADDR_DIR  = 2'h1;
  localparam logic [1:0] BWIO_ADDR_OPT  = 2'h2;
  localparam logic [1:0] BWIO_ADDR_TRIG = 2'h3;
  localparam logic [7:0] BWIO_RESET_VAL = 8'h00;
  localparam logic [1:0] BWIO_TRIG_RESET = 2'h0;
  // ****************************************************************
  // trigger modes
  // ****************************************************************
  localparam logic [1:0] BWIO_TRIG_FALL = 2'h0;
  localparam logic [1:0] BWIO_TRIG_RISE = 2'h1;
  localparam logic [1:0] BWIO_TRIG_LOW  = 2'h2;
  localparam int BWIO_WIDTH = 8;
endpackage

/* bwio_line.sv */
// one i/o line: pin drive, pull-up, interrupt and analog selection
`timescale 1ns/10ps
module bwio_line
  import bwio_pkg::*;
(
  input  wire logic dir,       // direction bit, 1 output
  input  wire logic opt,       // option bit
  input  wire logic dat,       // data latch bit
  input  wire logic pin_sync,  // synchronised pin level
  output logic      pin_out,   // pin output value
  output logic      pin_oe_n,  // pin enable, low drives
  output logic      pull_en,   // internal pull-up on
  output logic      irq_sel,   // line feeds interrupt
  output logic      ana_sel,   // line on converter mux
  output logic      read_bit   // value seen by a data read
);
  always_comb begin
    pin_out  = dat;
    pin_oe_n = 1'b1;
    pull_en  = 1'b0;
    irq_sel  = 1'b0;
    ana_sel  = 1'b0;
    read_bit = dat;
    if (dir) begin
      // open-drain drives low only; data bit does not change the kind
      pin_oe_n = opt ? 1'b0 : dat;
      pin_out  = opt ? dat : 1'b0;
    end else begin
      read_bit = pin_sync;
      case ({opt, dat})
        2'b00:   pull_en = 1'b1;
        2'b01:   pull_en = 1'b0;
        2'b10: begin
          pull_en = 1'b1;
          irq_sel = 1'b1;
        end
        2'b11: begin
          ana_sel  = 1'b1;
          read_bit = 1'b0;
        end
        default: pull_en = 1'b0;
      endcase
    end
  end
endmodule

/* bwio_pins.sv */
// pin-side model: board drivers, pull-ups and floating lines
`timescale 1ns/10ps
module bwio_pins (
  input  wire logic       ref_clk,  // system clock
  input  wire logic [7:0] pin_out,  // device drive value
  input  wire logic [7:0] pin_oe_n, // device enable, low drives
  input  wire logic [7:0] pull_en,  // device pull-ups
  input  wire logic [7:0] ext_en,   // board driver enable
  input  wire logic [7:0] ext_val,  // board driver value
  output logic      [7:0] pin_in    // resolved levels
);
  logic [7:0] last_r;
  always_ff @(posedge ref_clk) last_r <= pin_in;
  // a floating pin flips each cycle so a stale level never reads as valid
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pull_en[i] ? 1'b1 : ~last_r[i];
    end
  end
endmodule

/* tb.sv */
// self-checking bench for the bytewise i/o port
`timescale 1ns/10ps
module tb;
  import bwio_pkg::*;
  logic       ref_clk = 0, rst = 1, wr_en = 0, rd_en = 0, port_irq;
  logic [1:0] addr = '0;
  logic [7:0] wdata = '0, ext_en = '0, ext_val = '0;
  logic [7:0] rdata, pin_in, pin_out, pin_oe_n, pull_en, ana_sel;
  int         bad_count = 0, check_count = 0, n, k, cnt;
  // dir opt dat ext_en ext_val | oe_n pin_out pull ana read
  logic [7:0] tbl [0:5][0:9] = '{
    '{8'hff, 8'hff, 8'ha5, 8'h00, 8'h00, 8'h00, 8'ha5, 8'h00, 8'h00, 8'ha5},
    '{8'hff, 8'h00, 8'ha5, 8'h00, 8'h00, 8'ha5, 8'h00, 8'h00, 8'h00, 8'ha5},
    '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h05, 8'hff, 8'h00, 8'hff, 8'h00, 8'hf5},
    '{8'h00, 8'h00, 8'hff, 8'hff, 8'h3c, 8'hff, 8'h00, 8'h00, 8'h00, 8'h3c},
    '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'hff, 8'h00, 8'hfe, 8'h01, 8'hfe},
    '{8'h0f, 8'h0f, 8'h33, 8'hf0, 8'h50, 8'hf0, 8'h03, 8'hc0, 8'h00, 8'h53}};
  logic [7:0] irq_exp [0:3] = '{8'h01, 8'h01, 8'h08, 8'h00};
  always #2.5 ref_clk = ~ref_clk;
  bwio_port #(.W(8)) dut (.ref_clk, .rst, .addr, .wr_en, .rd_en, .wdata, .rdata,
    .pin_in, .pin_out, .pin_oe_n, .pull_en, .ana_sel, .port_irq);
  bwio_pins pins (.ref_clk, .pin_out, .pin_oe_n, .pull_en, .ext_en, .ext_val, .pin_in);
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(negedge ref_clk);
    addr = a; wdata = d; wr_en = 1;
    @(negedge ref_clk);
    wr_en = 0;
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] exp);
    @(negedge ref_clk);
    addr = a; rd_en = 1;
    @(negedge ref_clk);
    rd_en = 0;
    chk("rdata", exp, rdata);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    cyc(16);
    rst = 0;
    chk("oe_n", 8'hff, pin_oe_n);
    chk("pull", 8'hff, pull_en);
    chk("irq", 8'h00, {7'h0, port_irq});
    for (n = 1; n < 4; n++) rd(n[1:0], 8'h00);
    for (n = 0; n < 6; n++) begin
      wr(BWIO_ADDR_DIR, tbl[n][0]);
      wr(BWIO_ADDR_OPT, tbl[n][1]);
      wr(BWIO_ADDR_DATA, tbl[n][2]);
      ext_en = tbl[n][3];
      ext_val = tbl[n][4];
      cyc(4);
      chk("oe_n", tbl[n][5], pin_oe_n);
      chk("pin_out", tbl[n][6], pin_out & ~pin_oe_n);
      chk("pull", tbl[n][7], pull_en);
      chk("ana", tbl[n][8], ana_sel);
      rd(BWIO_ADDR_DATA, tbl[n][9]);
      rd(BWIO_ADDR_OPT, tbl[n][1]);
    end
    // line 2 feeds the interrupt, line 3 is a plain pull-up that must not;
    // data goes first so that no two lines are ever analog together
    ext_en = 8'h0c;
    ext_val = 8'h04;
    wr(BWIO_ADDR_DATA, 8'h00);
    wr(BWIO_ADDR_OPT, 8'h04);
    wr(BWIO_ADDR_DIR, 8'h00);
    for (n = 0; n < 4; n++) begin
      wr(BWIO_ADDR_TRIG, n[7:0]);
      ext_val = 8'h04;
      cyc(6);
      cnt = 0;
      ext_val = 8'h08;
      for (k = 0; k < 16; k++) begin
        if (k == 8) ext_val = 8'h0c;
        cyc(1);
        cnt += port_irq;
      end
      chk("irq_cycles", irq_exp[n], cnt[7:0]);
    end
    // leave outputs and one analog line set so that the mid-run reset has work
    wr(BWIO_ADDR_DATA, 8'h10);
    wr(BWIO_ADDR_OPT, 8'h10);
    wr(BWIO_ADDR_DIR, 8'h0f);
    cyc(1);
    chk("ana", 8'h10, ana_sel);
    chk("oe_n", 8'hf0, pin_oe_n);
    rst = 1;
    cyc(2);
    chk("oe_n", 8'hff, pin_oe_n);
    chk("ana", 8'h00, ana_sel);
    chk("pull", 8'hff, pull_en);
    rst = 0;
    rd(BWIO_ADDR_OPT, 8'h00);
    rd(BWIO_ADDR_DIR, 8'h00);
    tally_and_finish;
  end
endmodule
